// ### src/i2c_slave_defs.svh
// constants for the two-wire slave with stall time-out
// assumes inclusion by the slave package users only
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH
`define TOC_EN_BIT 7
`define TOC_FLAG_BIT 6
`define TOC_SEL_MSB 5
`define TOC_RESET_VAL 8'h00
`define TO_LOW_SPEED_INTERNAL_OSC_PER_STEP 32
`define BYTE_BITS 4'h8
`define ACK_BIT_IDX 4'h9
`define SYNC_STAGES 2
`define FIFO_DEPTH 4
`endif

// ### src/i2c_slave_pkg.sv
// types shared by the two-wire slave and its bench
// assumes defs header compiled alongside
package i2c_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_HOLD = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_ACK = 3'b101,
    ST_SKIP = 3'b110
  } slave_state_e;
  typedef struct packed {
    logic bus_busy_flag;
    logic address_match_flag;
    logic master_direction_flag;
    logic ack_received_flag;
    logic byte_done_flag;
  } slave_status_s;
  typedef logic [7:0] byte_t;
endpackage : i2c_slave_pkg

// ### src/byte_fifo.sv
// small ready/valid fifo carrying received bytes
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ### src/i2c_slave_with_timeout.sv
// two-wire bus slave with clock stretching and stall time-out
// assumes open-drain pins resolved outside; low-speed tick from same clock
`timescale 1ns/1ps
`include "i2c_slave_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE_01] start is sda fall while scl high
// [RULE_02] start sets bus busy flag
// [RULE_03] match seven address bits, raise interrupt
// [RULE_04] eighth bit is master direction
// [RULE_05] match drives ack, sets match flag
// [RULE_06] firmware tests match flag in handler
// [RULE_07] hold scl until firmware services data
// [RULE_08] firmware sets transmit select from direction
// [RULE_09] bytes eight bits, msb first
// [RULE_10] receive: drive ack_to_send on ninth clock
// [RULE_11] transmit nack: release sda
// [RULE_12] firmware checks ack flag per byte
// [RULE_13] master stops after address nack
// [RULE_14] timer starts on match, clears on scl fall
// [RULE_15] stall longer than period gives time-out
// [RULE_16] time-out stops, clears enable, sets flag, interrupts
// [RULE_17] time-out resets serial logic and status
// [RULE_18] period (select+1) times 32 oscillator ticks
// [RULE_19] oscillator tick runs free
// [RULE_20] control: enable 7, flag 6, select 5..0
// [RULE_21] ack flag 0 acked, 1 not
// [RULE_22] stop clears bus busy flag
// [RULE_23] pins open-drain, scl held while stretching
module i2c_slave_with_timeout
  import i2c_slave_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic low_speed_internal_osc_tick,
  input wire logic [6:0] own_address,
  input wire logic slave_transmit_select,
  input wire logic ack_to_send,
  input wire logic [7:0] tx_data,
  input wire logic tx_write,
  input wire logic data_read,
  output byte_t rx_data,
  output logic rx_valid,
  input wire logic toc_write,
  input wire logic [7:0] toc_wdata,
  output logic [7:0] timeout_control_register,
  output slave_status_s status,
  output logic serial_irq_flag
);
  logic [1:0] scl_sy_ff;
  logic [1:0] sda_sy_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [1:0] tick_sy_ff;
  logic tick_d_ff;
  slave_state_e st_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic busy_ff, match_ff, dir_ff, ack_received_flag_ff, done_ff, irq_ff;
  logic stretch_ff, sda_low_ff;
  logic to_en_ff, to_flag_ff, to_run_ff;
  logic [5:0] to_sel_ff;
  logic [10:0] to_cnt_ff;
  logic scl_rise, scl_fall, start_det, stop_det, tick, to_hit;
  logic fifo_in_ready, fifo_push;
  logic [11:0] to_limit;
  ////////////////////////////////////////////////////////////////////////////////
  // pin and tick synchronisers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      tick_sy_ff <= 2'h0;
      tick_d_ff <= 1'b0;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], scl_in};
      sda_sy_ff <= {sda_sy_ff[0], sda_in};
      scl_d_ff <= scl_sy_ff[1];
      sda_d_ff <= sda_sy_ff[1];
      tick_sy_ff <= {tick_sy_ff[0], low_speed_internal_osc_tick};
      tick_d_ff <= tick_sy_ff[1];
    end
  end
  assign scl_rise = scl_sy_ff[1] && !scl_d_ff;
  assign scl_fall = !scl_sy_ff[1] && scl_d_ff;
  // [RULE_01] start condition detect
  assign start_det = scl_sy_ff[1] && scl_d_ff && sda_d_ff && !sda_sy_ff[1];
  assign stop_det = scl_sy_ff[1] && scl_d_ff && !sda_d_ff && sda_sy_ff[1];
  // [RULE_19] free-running oscillator tick edge
  assign tick = tick_sy_ff[1] && !tick_d_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // bus busy tracking
  always_ff @(posedge core_clk) begin
    if (srst || to_hit) begin
      busy_ff <= 1'b0;
    end else if (start_det) begin
      // [RULE_02] start marks bus busy
      busy_ff <= 1'b1;
    end else if (stop_det) begin
      // [RULE_22] stop frees bus
      busy_ff <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bit engine
  always_ff @(posedge core_clk) begin
    if (srst || to_hit) begin
      // [RULE_17] time-out resets serial logic
      st_ff <= ST_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      match_ff <= 1'b0;
      dir_ff <= 1'b0;
      ack_received_flag_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_ff <= 1'b0;
      stretch_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (start_det) begin
      st_ff <= ST_ADDR;
      bit_ff <= 4'h0;
      match_ff <= 1'b0;
      done_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      stretch_ff <= 1'b0;
    end else if (stop_det) begin
      st_ff <= ST_IDLE;
      sda_low_ff <= 1'b0;
      stretch_ff <= 1'b0;
    end else begin
      irq_ff <= 1'b0;
      case (st_ff)
        ST_IDLE, ST_SKIP: begin
          sda_low_ff <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            // [RULE_09] msb-first shift
            sh_ff <= {sh_ff[6:0], sda_sy_ff[1]};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == `BYTE_BITS) begin
            // [RULE_03] compare seven address bits
            if (sh_ff[7:1] == own_address) begin
              // [RULE_04] eighth bit is direction
              dir_ff <= sh_ff[0];
              // [RULE_05] ack and flag on match
              match_ff <= 1'b1;
              sda_low_ff <= 1'b1;
              irq_ff <= 1'b1;
              st_ff <= ST_ACK;
              bit_ff <= 4'h0;
            end else begin
              st_ff <= ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_low_ff <= 1'b0;
            // [RULE_07] stretch until data register serviced
            stretch_ff <= 1'b1;
            st_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (slave_transmit_select && tx_write) begin
            stretch_ff <= 1'b0;
            match_ff <= 1'b0;
            sh_ff <= tx_data;
            sda_low_ff <= !tx_data[7];
            bit_ff <= 4'h0;
            st_ff <= ST_TX;
          end else if (!slave_transmit_select && data_read && fifo_in_ready) begin
            stretch_ff <= 1'b0;
            match_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            bit_ff <= 4'h0;
            st_ff <= ST_RX;
          end
        end
        ST_RX: begin
          if (scl_rise && bit_ff < `BYTE_BITS) begin
            sh_ff <= {sh_ff[6:0], sda_sy_ff[1]};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == `BYTE_BITS) begin
            // [RULE_10] ninth clock carries ack_to_send
            sda_low_ff <= !ack_to_send;
            done_ff <= 1'b1;
            irq_ff <= 1'b1;
            bit_ff <= `ACK_BIT_IDX;
          end else if (scl_fall && bit_ff == `ACK_BIT_IDX) begin
            sda_low_ff <= 1'b0;
            stretch_ff <= 1'b1;
            st_ff <= ST_HOLD;
          end
        end
        ST_TX: begin
          if (scl_fall && bit_ff < 4'h7) begin
            sda_low_ff <= !sh_ff[6];
            sh_ff <= {sh_ff[6:0], 1'b0};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h7) begin
            sda_low_ff <= 1'b0;
            bit_ff <= `BYTE_BITS;
          end else if (scl_rise && bit_ff == `BYTE_BITS) begin
            // [RULE_21] ack sampled on ninth clock
            ack_received_flag_ff <= sda_sy_ff[1];
            bit_ff <= `ACK_BIT_IDX;
          end else if (scl_fall && bit_ff == `ACK_BIT_IDX) begin
            done_ff <= 1'b1;
            irq_ff <= 1'b1;
            // [RULE_11] release sda after master nack
            if (ack_received_flag_ff) begin
              st_ff <= ST_SKIP;
            end else begin
              stretch_ff <= 1'b1;
              st_ff <= ST_HOLD;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // received byte buffer
  assign fifo_push = (st_ff == ST_RX) && scl_fall && (bit_ff == `BYTE_BITS);
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(sh_ff),
    .out_valid(rx_valid),
    .out_ready(data_read),
    .out_data(rx_data)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // time-out control and counter
  // [RULE_18] limit (select+1) times 32 ticks
  // twelve bits so the longest period does not wrap
  assign to_limit = ({6'h00, to_sel_ff} + 12'h001) * 12'(`TO_LOW_SPEED_INTERNAL_OSC_PER_STEP);
  // [RULE_15] stall past period
  assign to_hit = to_run_ff && to_en_ff && tick && ({1'b0, to_cnt_ff} + 12'h001 >= to_limit);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      to_en_ff <= 1'b0;
      to_flag_ff <= 1'b0;
      to_sel_ff <= 6'h00;
    end else if (to_hit) begin
      // [RULE_16] clear enable, set flag
      to_en_ff <= 1'b0;
      to_flag_ff <= 1'b1;
    end else if (toc_write) begin
      // [RULE_20] control field layout
      to_en_ff <= toc_wdata[`TOC_EN_BIT];
      to_flag_ff <= toc_wdata[`TOC_FLAG_BIT];
      to_sel_ff <= toc_wdata[`TOC_SEL_MSB:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst || to_hit) begin
      to_run_ff <= 1'b0;
      to_cnt_ff <= 11'h000;
    end else if (stop_det) begin
      to_run_ff <= 1'b0;
      to_cnt_ff <= 11'h000;
    end else if (st_ff == ST_ADDR && scl_fall && bit_ff == `BYTE_BITS
                 && sh_ff[7:1] == own_address) begin
      // [RULE_14] start on match, clear on scl fall
      to_run_ff <= 1'b1;
      to_cnt_ff <= 11'h000;
    end else if (scl_fall) begin
      to_cnt_ff <= 11'h000;
    end else if (to_run_ff && tick) begin
      to_cnt_ff <= to_cnt_ff + 11'h001;
    end
  end
  assign timeout_control_register = {to_en_ff, to_flag_ff, to_sel_ff};
  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  // [RULE_23] open-drain drive
  assign scl_out = 1'b0;
  assign scl_oe = stretch_ff;
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_ff;
  assign status = '{bus_busy_flag: busy_ff, address_match_flag: match_ff,
                    master_direction_flag: dir_ff, ack_received_flag: ack_received_flag_ff,
                    byte_done_flag: done_ff};
  // [RULE_16] interrupt pulse on time-out too
  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial_irq_flag <= 1'b0;
    end else begin
      serial_irq_flag <= irq_ff || to_hit;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // checks
  chk_start_busy: assert property (@(posedge core_clk) disable iff (srst) // [RULE_02]
    start_det && !to_hit |=> busy_ff) else $error("start did not set busy");
  chk_stop_free: assert property (@(posedge core_clk) disable iff (srst) // [RULE_22]
    stop_det && !start_det |=> !busy_ff) else $error("stop did not clear busy");
  chk_match_ack: assert property (@(posedge core_clk) disable iff (srst) // [RULE_05]
    $rose(match_ff) |-> sda_oe && irq_ff) else $error("match without ack");
  chk_hold_stretch: assert property (@(posedge core_clk) disable iff (srst) // [RULE_07]
    st_ff == ST_HOLD && stretch_ff && !tx_write && !data_read && !stop_det
    && !start_det && !to_hit |=> scl_oe) else $error("scl released early");
  chk_timeout_effect: assert property (@(posedge core_clk) disable iff (srst) // [RULE_16]
    to_hit |=> !to_en_ff && to_flag_ff && serial_irq_flag && st_ff == ST_IDLE)
    else $error("time-out effects missing");
  chk_timeout_reset: assert property (@(posedge core_clk) disable iff (srst) // [RULE_17]
    to_hit |=> !match_ff && !scl_oe && !sda_oe) else $error("serial not reset");
  chk_fall_clears: assert property (@(posedge core_clk) disable iff (srst) // [RULE_14]
    scl_fall && !to_hit |=> to_cnt_ff == 11'h000) else $error("count not cleared");
  chk_limit_value: assert property (@(posedge core_clk) disable iff (srst) // [RULE_18]
    to_limit == (12'(to_sel_ff) + 12'h001) << 5) else $error("bad limit");
  chk_nack_release: assert property (@(posedge core_clk) disable iff (srst) // [RULE_11]
    st_ff == ST_SKIP |-> !sda_oe) else $error("sda held after nack");
  cov_match: cover property (@(posedge core_clk) $rose(match_ff));
  cov_timeout: cover property (@(posedge core_clk) to_hit);
  cov_rx_byte: cover property (@(posedge core_clk) fifo_push);
  cov_tx_nack: cover property (@(posedge core_clk) $rose(ack_received_flag_ff));
endmodule : i2c_slave_with_timeout

// ### tb/i2c_master_model.sv
// external two-wire bus master, behavioural, open-drain with pull-ups
// assumes the bench calls its tasks; phases of 8 core cycles
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic core_clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // released lines float to the pull-up level
  assign scl_line = !(scl_low || scl_oe);
  assign sda_line = !(sda_low || sda_oe);
  task automatic half();
    repeat (8) @(negedge core_clk);
  endtask : half
  task automatic clk_pulse(output logic b);
    int n;
    n = 0;
    half();
    scl_low = 1'b0;
    while (!scl_line && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    half();
    b = sda_line;
    scl_low = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask : clk_pulse
  task automatic start_cond();
    sda_low = 1'b0;
    scl_low = 1'b0;
    half();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    sda_low = 1'b1;
    half();
    scl_low = 1'b0;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] v, output logic nack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_low = !v[i];
      clk_pulse(b);
    end
    sda_low = 1'b0;
    clk_pulse(nack);
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] v);
    logic b;
    sda_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      clk_pulse(b);
      v = {v[6:0], b};
    end
    sda_low = !nack;
    clk_pulse(b);
    sda_low = 1'b0;
  endtask : recv_byte
endmodule : i2c_master_model

// ### tb/i2c_slave_with_timeout_bench.sv
// self-checking bench for the two-wire slave with stall time-out
// assumes the master model and the design sources are compiled first
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module i2c_slave_with_timeout_bench;
  import i2c_slave_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic scl_line, sda_line, scl_oe, sda_oe;
  logic low_speed_internal_osc_tick = 1'b0;
  logic [6:0] own_addr = 7'h3a;
  logic tx_sel = 1'b0;
  logic ack_to_send = 1'b0;
  byte_t tx_data = 8'h00;
  logic tx_write = 1'b0;
  logic data_read = 1'b0;
  byte_t rx_data;
  logic rx_valid;
  logic toc_write = 1'b0;
  logic [7:0] toc_wdata = 8'h00;
  logic [7:0] toc_reg;
  slave_status_s status;
  logic irq;
  logic scl_drv, sda_drv;
  int n_errors = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  always #50 core_clk = !core_clk;
  always begin
    repeat (4) @(negedge core_clk);
    low_speed_internal_osc_tick = !low_speed_internal_osc_tick;
  end
  always @(posedge core_clk) begin
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
  i2c_master_model partner_u (.core_clk(core_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_line(scl_line), .sda_line(sda_line));
  i2c_slave_with_timeout #(.FIFO_DEPTH(4)) dut_u (.core_clk(core_clk), .srst(srst),
    .scl_in(scl_line), .scl_out(scl_drv), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_drv), .sda_oe(sda_oe), .low_speed_internal_osc_tick(low_speed_internal_osc_tick), .own_address(own_addr),
    .slave_transmit_select(tx_sel), .ack_to_send(ack_to_send), .tx_data(tx_data),
    .tx_write(tx_write), .data_read(data_read), .rx_data(rx_data), .rx_valid(rx_valid),
    .toc_write(toc_write), .toc_wdata(toc_wdata), .timeout_control_register(toc_reg),
    .status(status), .serial_irq_flag(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask : settle
  task automatic fw_read();
    data_read = 1'b1;
    @(negedge core_clk);
    data_read = 1'b0;
    settle();
  endtask : fw_read
  task automatic fw_write(input byte_t d);
    tx_data = d;
    tx_write = 1'b1;
    @(negedge core_clk);
    tx_write = 1'b0;
    settle();
  endtask : fw_write
  task automatic toc_set(input logic [7:0] d);
    toc_wdata = d;
    toc_write = 1'b1;
    @(negedge core_clk);
    toc_write = 1'b0;
    settle();
  endtask : toc_set
  task automatic addr_phase(input logic [6:0] a, input logic rw, output logic nack);
    partner_u.start_cond();
    partner_u.send_byte({a, rw}, nack);
    settle();
  endtask : addr_phase
  task automatic tend(input string name);
    $display("test %s done", name);
  endtask : tend
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    report_and_stop();
  end
  initial begin
    logic nk;
    byte_t v;
    int i0;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    settle();
    `CHECK("toc reset", 8'h00, toc_reg)
    `CHECK("status reset", 5'h00, status)
    `CHECK("open drain", 2'b00, {scl_drv, sda_drv})
    toc_set(8'h3f);
    `CHECK("toc select", 8'h3f, toc_reg)
    tend("reset");
    i0 = irq_cnt;
    addr_phase(own_addr ^ 7'h01, 1'b0, nk);
    `CHECK("other addr nack", 1'b1, nk)
    `CHECK("busy on start", 1'b1, status.bus_busy_flag)
    `CHECK("no match", 1'b0, status.address_match_flag)
    `CHECK("no irq", i0, irq_cnt)
    partner_u.stop_cond();
    settle();
    `CHECK("busy after stop", 1'b0, status.bus_busy_flag)
    tend("mismatch");
    toc_set(8'h80);
    i0 = irq_cnt;
    addr_phase(own_addr, 1'b0, nk);
    `CHECK("addr ack", 1'b0, nk)
    `CHECK("match flag", 1'b1, status.address_match_flag)
    `CHECK("dir write", 1'b0, status.master_direction_flag)
    `CHECK("match irq", i0 + 1, irq_cnt)
    `CHECK("stretch", 1'b1, scl_oe)
    fw_read();
    `CHECK("stretch released", 1'b0, scl_oe)
    for (int k = 0; k < 2; k++) begin
      ack_to_send = k[0];
      partner_u.send_byte(8'ha5 ^ k[7:0], nk);
      settle();
      `CHECK("ack sent", ack_to_send, nk)
      `CHECK("rx valid", 1'b1, rx_valid)
      `CHECK("rx data", 8'ha5 ^ k[7:0], rx_data)
      fw_read();
    end
    `CHECK("rx empty", 1'b0, rx_valid)
    `CHECK("irq per byte", i0 + 3, irq_cnt)
    `CHECK("falls restart timer", 1'b0, toc_reg[6])
    ack_to_send = 1'b0;
    partner_u.stop_cond();
    repeat (300) @(negedge core_clk);
    `CHECK("stop halts timer", 8'h80, toc_reg)
    tend("receive");
    addr_phase(own_addr, 1'b1, nk);
    `CHECK("dir read", 1'b1, status.master_direction_flag)
    tx_sel = 1'b1;
    fw_write(8'hc3);
    `CHECK("tx releases", 1'b0, scl_oe)
    partner_u.recv_byte(1'b0, v);
    settle();
    `CHECK("tx byte", 8'hc3, v)
    `CHECK("acked", 1'b0, status.ack_received_flag)
    fw_write(8'h5a);
    partner_u.recv_byte(1'b1, v);
    settle();
    `CHECK("tx byte2", 8'h5a, v)
    `CHECK("not acked", 1'b1, status.ack_received_flag)
    `CHECK("sda released", 1'b0, sda_oe)
    partner_u.stop_cond();
    tx_sel = 1'b0;
    settle();
    tend("transmit");
    toc_set(8'h81);
    i0 = irq_cnt;
    addr_phase(own_addr, 1'b0, nk);
    repeat (464) @(negedge core_clk);
    `CHECK("no early timeout", 1'b0, toc_reg[6])
    for (int k = 0; k < 200 && toc_reg[6] !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    settle();
    `CHECK("timeout reg", 8'h41, toc_reg)
    `CHECK("timeout irq", i0 + 2, irq_cnt)
    `CHECK("status cleared", 5'h00, status)
    `CHECK("scl freed", 1'b0, scl_oe)
    toc_set(8'h01);
    `CHECK("flag cleared", 8'h01, toc_reg)
    partner_u.stop_cond();
    tend("timeout");
    addr_phase(own_addr, 1'b0, nk);
    fw_read();
    for (int k = 0; k < 3; k++) begin
      partner_u.send_byte(8'h10 + k[7:0], nk);
      settle();
      `CHECK("fifo in", 1'b1, rx_valid)
      `CHECK("fifo out", 8'h10 + k[7:0], rx_data)
      fw_read();
    end
    `CHECK("fifo drained", 1'b0, rx_valid)
    partner_u.stop_cond();
    settle();
    tend("fifo");
    report_and_stop();
  end
endmodule : i2c_slave_with_timeout_bench
